// ===== hw/xfer_pkg.sv
// shared constants and types for the data transfer executor
package xfer_pkg;
  // operation classes presented by the instruction decoder
  typedef enum logic [2:0] {
    OP_LOAD,   // (ea) -> register
    OP_STORE,  // register -> (ea)
    OP_SYNC,   // e clock synchronised byte move, direction bit picks way
    OP_PUSH,
    OP_POP
  } op_type;
  // addressing modes of the general transfer instruction
  typedef enum logic [2:0] {
    MODE_REG,
    MODE_IND,
    MODE_DISP,
    MODE_ABS16,
    MODE_ABS8,
    MODE_IMM,
    MODE_PREDEC,
    MODE_POSTINC
  } mode_type;
  localparam int NUM_REGS = 8;
  localparam logic [2:0] SP_INDEX = 3'h7;
  localparam logic [15:0] REG_RESET = 16'h0000;
  localparam logic [7:0] ABS8_PAGE = 8'hff;
  localparam logic [15:0] STEP_BYTE = 16'h0001;
  localparam logic [15:0] STEP_WORD = 16'h0002;
  localparam logic DIR_LOAD = 1'b0;
  localparam logic DIR_STORE = 1'b1;
  // e clock is the system clock divided by this count
  localparam int E_DIV = 8;
  localparam logic [3:0] E_DIV_LAST = 4'(E_DIV - 1);
  localparam logic [3:0] E_HALF = 4'(E_DIV / 2);
endpackage : xfer_pkg

// ===== hw/e_clock_div.sv
// divider that makes the slow peripheral e clock and its start pulse
`timescale 1ns/1ps
module e_clock_div (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // e clock outputs
  output logic e_clk,
  output logic e_tick
);
  logic [3:0] cnt_r;
  logic [3:0] cnt_nxt;
  logic e_clk_r;
  logic e_clk_nxt;

  // free running count, high half of the period drives e_clk
  always_comb begin
    cnt_nxt = (cnt_r == xfer_pkg::E_DIV_LAST) ? 4'h0 : cnt_r + 4'h1;
    e_clk_nxt = (cnt_nxt >= xfer_pkg::E_HALF);
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      cnt_r <= 4'h0;
      e_clk_r <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      e_clk_r <= e_clk_nxt;
    end
  end

  assign e_clk = e_clk_r;
  assign e_tick = (cnt_r == xfer_pkg::E_DIV_LAST); // last cycle of e period
endmodule : e_clock_div

// ===== hw/xfer_exec.sv
// executor for the data transfer instruction group
// What this block does
// (RULE_01) moves between registers, memory, immediate
// (RULE_02) byte and word in all listed modes
// (RULE_03) absolute eight bit mode only for bytes
// (RULE_04) software uses word size for stack steps
// (RULE_05) synced store writes byte on e clock
// (RULE_06) synced load reads byte on e clock
// (RULE_07) direction bit zero loads, one stores
// (RULE_08) push predecrements stack, stores word
// (RULE_09) pop loads word, then increments stack
// (RULE_10) word accesses force address bit zero low
// (RULE_11) immediate byte or word, loads only
// (RULE_12) register field picks word or byte half
`timescale 1ns/1ps
module xfer_exec (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // decoded instruction
  input wire logic start,
  input wire xfer_pkg::op_type op,
  input wire xfer_pkg::mode_type mode,
  input wire logic size_word,
  input wire logic dir,
  input wire logic [3:0] reg_field,
  input wire logic [3:0] ea_field,
  input wire logic [15:0] ext,
  // completion
  output logic busy,
  output logic done,
  output logic illegal,
  // memory and peripheral bus
  output logic mem_req,
  output logic mem_we,
  output logic mem_word,
  output logic mem_sync,
  output logic [15:0] mem_addr,
  output logic [15:0] mem_wdata,
  input wire logic mem_ack,
  input wire logic [15:0] mem_rdata,
  // e clock pin and register view
  output logic e_clk,
  input wire logic [2:0] view_sel,
  output logic [15:0] view_data
);
  typedef enum logic [1:0] {S_IDLE, S_EWAIT, S_MEM} state_type;
  state_type state_r, state_nxt;
  logic [15:0] regs_r [xfer_pkg::NUM_REGS];
  logic [15:0] regs_nxt [xfer_pkg::NUM_REGS];
  logic [15:0] addr_r, addr_nxt, wdata_r, wdata_nxt, view_r;
  logic we_r, we_nxt, word_r, word_nxt, sync_r, sync_nxt;
  logic [3:0] dst_r, dst_nxt;
  logic [2:0] inc_reg_r, inc_reg_nxt;
  logic inc_r, inc_nxt, done_r, done_nxt, ill_r, ill_nxt;
  logic e_tick;
  logic accept;
  logic [15:0] base, step, ea;
  logic [2:0] ea_idx;
  logic bad;
  e_clock_div u_ediv (
    .clk(clk),
    .rstn(rstn),
    .e_clk(e_clk),
    .e_tick(e_tick)
  );
  // byte lane select: bit 3 set picks the low half
  function automatic logic [15:0] rd_reg(input logic [15:0] w,
                                         input logic word,
                                         input logic lo);
    if (word) rd_reg = w;
    else rd_reg = lo ? {8'h00, w[7:0]} : {8'h00, w[15:8]};
  endfunction : rd_reg
  // write keeps the other byte half untouched in byte size
  function automatic logic [15:0] wr_reg(input logic [15:0] old,
                                         input logic [15:0] v,
                                         input logic word,
                                         input logic lo);
    if (word) wr_reg = v;
    else if (lo) wr_reg = {old[15:8], v[7:0]};
    else wr_reg = {v[7:0], old[7:0]};
  endfunction : wr_reg
  assign accept = start && (state_r == S_IDLE);
  // effective address; push and pop use the stack pointer
  always_comb begin
    ea_idx = (op == xfer_pkg::OP_PUSH || op == xfer_pkg::OP_POP) ?
             xfer_pkg::SP_INDEX : ea_field[2:0];
    base = regs_r[ea_idx];
    step = size_word ? xfer_pkg::STEP_WORD : xfer_pkg::STEP_BYTE;
    case (mode)
      xfer_pkg::MODE_DISP: ea = base + ext;
      xfer_pkg::MODE_ABS16: ea = ext;
      xfer_pkg::MODE_ABS8: ea = {xfer_pkg::ABS8_PAGE, ext[7:0]};
      xfer_pkg::MODE_PREDEC: ea = base - step;
      default: ea = base;
    endcase
    if (op == xfer_pkg::OP_PUSH) ea = base - xfer_pkg::STEP_WORD; // [RULE_08]
    if (op == xfer_pkg::OP_POP) ea = base; // mode input ignored [RULE_09]
    if (op == xfer_pkg::OP_SYNC) ea = ext;
    // combinations the device refuses instead of executing
    bad = 1'b0;
    if (op == xfer_pkg::OP_LOAD || op == xfer_pkg::OP_STORE) begin
      if (mode == xfer_pkg::MODE_ABS8 && size_word) bad = 1'b1; // [RULE_03]
      if (mode == xfer_pkg::MODE_IMM && op == xfer_pkg::OP_STORE) bad = 1'b1;
      // stack register stepping by one would misalign the stack
      if ((mode == xfer_pkg::MODE_PREDEC || mode == xfer_pkg::MODE_POSTINC)
          && ea_idx == xfer_pkg::SP_INDEX && !size_word) bad = 1'b1; // [RULE_04]
    end
  end
  // sequencing and register file next values
  always_comb begin
    state_nxt = state_r;
    for (int i = 0; i < xfer_pkg::NUM_REGS; i++) regs_nxt[i] = regs_r[i];
    addr_nxt = addr_r;
    wdata_nxt = wdata_r;
    we_nxt = we_r;
    word_nxt = word_r;
    sync_nxt = sync_r;
    dst_nxt = dst_r;
    inc_reg_nxt = inc_reg_r;
    inc_nxt = inc_r;
    done_nxt = 1'b0;
    ill_nxt = 1'b0;
    case (state_r)
      S_IDLE: begin
        if (accept && bad) begin
          ill_nxt = 1'b1;
          done_nxt = 1'b1;
        end else if (accept) begin
          word_nxt = size_word;
          sync_nxt = 1'b0;
          inc_nxt = 1'b0;
          dst_nxt = reg_field;
          inc_reg_nxt = ea_idx;
          we_nxt = (op == xfer_pkg::OP_STORE);
          wdata_nxt = rd_reg(regs_r[reg_field[2:0]], size_word,
                             reg_field[3]); // [RULE_12]
          addr_nxt = size_word ? {ea[15:1], 1'b0} : ea; // [RULE_10]
          state_nxt = S_MEM;
          case (op)
            xfer_pkg::OP_SYNC: begin
              word_nxt = 1'b0; // byte only [RULE_05] [RULE_06]
              sync_nxt = 1'b1;
              we_nxt = (dir == xfer_pkg::DIR_STORE); // [RULE_07]
              wdata_nxt = rd_reg(regs_r[reg_field[2:0]], 1'b0, reg_field[3]);
              addr_nxt = ea;
              state_nxt = S_EWAIT;
            end
            xfer_pkg::OP_PUSH: begin
              word_nxt = 1'b1;
              we_nxt = 1'b1;
              wdata_nxt = regs_r[reg_field[2:0]];
              addr_nxt = {ea[15:1], 1'b0};
              regs_nxt[xfer_pkg::SP_INDEX] = ea; // [RULE_08]
            end
            xfer_pkg::OP_POP: begin
              word_nxt = 1'b1;
              we_nxt = 1'b0;
              dst_nxt = {1'b0, reg_field[2:0]};
              addr_nxt = {ea[15:1], 1'b0};
              inc_nxt = 1'b1; // stack steps after the read [RULE_09]
            end
            default: begin
              case (mode)
                xfer_pkg::MODE_REG: begin
                  // register to register, no bus cycle [RULE_01]
                  if (op == xfer_pkg::OP_LOAD)
                    regs_nxt[reg_field[2:0]] = wr_reg(regs_r[reg_field[2:0]],
                      rd_reg(regs_r[ea_field[2:0]], size_word, ea_field[3]),
                      size_word, reg_field[3]); // [RULE_12]
                  else
                    regs_nxt[ea_field[2:0]] = wr_reg(regs_r[ea_field[2:0]],
                      wdata_nxt, size_word, ea_field[3]);
                  state_nxt = S_IDLE;
                  done_nxt = 1'b1;
                end
                xfer_pkg::MODE_IMM: begin
                  // byte takes second byte, word the two extension bytes
                  regs_nxt[reg_field[2:0]] = wr_reg(regs_r[reg_field[2:0]],
                    size_word ? ext : {8'h00, ext[7:0]},
                    size_word, reg_field[3]); // [RULE_11]
                  state_nxt = S_IDLE;
                  done_nxt = 1'b1;
                end
                xfer_pkg::MODE_PREDEC:
                  regs_nxt[ea_idx] = ea; // [RULE_02]
                xfer_pkg::MODE_POSTINC:
                  inc_nxt = 1'b1; // [RULE_02]
                default: ;
              endcase
            end
          endcase
        end
      end
      S_EWAIT: begin
        // start the slow cycle on an e clock boundary
        if (e_tick) state_nxt = S_MEM; // [RULE_05] [RULE_06]
      end
      S_MEM: begin
        if (mem_ack) begin
          if (!we_r)
            regs_nxt[dst_r[2:0]] = wr_reg(regs_r[dst_r[2:0]],
              word_r ? mem_rdata : {8'h00, mem_rdata[7:0]},
              word_r, dst_r[3]); // [RULE_01]
          // increment wins over a load into the same register
          if (inc_r)
            regs_nxt[inc_reg_r] = regs_r[inc_reg_r] +
              (word_r ? xfer_pkg::STEP_WORD : xfer_pkg::STEP_BYTE); // [RULE_09]
          state_nxt = S_IDLE;
          done_nxt = 1'b1;
        end
      end
      default: state_nxt = S_IDLE;
    endcase
  end
  always_ff @(posedge clk) begin
    if (!rstn) begin
      state_r <= S_IDLE;
      for (int i = 0; i < xfer_pkg::NUM_REGS; i++)
        regs_r[i] <= xfer_pkg::REG_RESET;
      addr_r <= 16'h0000;
      wdata_r <= 16'h0000;
      we_r <= 1'b0;
      word_r <= 1'b0;
      sync_r <= 1'b0;
      dst_r <= 4'h0;
      inc_reg_r <= 3'h0;
      inc_r <= 1'b0;
      done_r <= 1'b0;
      ill_r <= 1'b0;
      view_r <= 16'h0000;
    end else begin
      state_r <= state_nxt;
      for (int i = 0; i < xfer_pkg::NUM_REGS; i++) regs_r[i] <= regs_nxt[i];
      addr_r <= addr_nxt;
      wdata_r <= wdata_nxt;
      we_r <= we_nxt;
      word_r <= word_nxt;
      sync_r <= sync_nxt;
      dst_r <= dst_nxt;
      inc_reg_r <= inc_reg_nxt;
      inc_r <= inc_nxt;
      done_r <= done_nxt;
      ill_r <= ill_nxt;
      view_r <= regs_r[view_sel];
    end
  end
  // outputs
  assign busy = (state_r != S_IDLE);
  assign done = done_r;
  assign illegal = ill_r;
  assign mem_req = (state_r == S_MEM);
  assign mem_we = we_r;
  assign mem_word = word_r;
  assign mem_sync = sync_r;
  assign mem_addr = addr_r;
  assign mem_wdata = wdata_r;
  assign view_data = view_r;
  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  AST_WORD_EVEN: assert property ( // [RULE_10]
    mem_req && mem_word |-> !mem_addr[0])
    else $error("word access at odd address");
  AST_ABS8_WORD: assert property ( // [RULE_03]
    accept && op inside {xfer_pkg::OP_LOAD, xfer_pkg::OP_STORE} &&
    mode == xfer_pkg::MODE_ABS8 && size_word |=> illegal && done)
    else $error("word absolute eight bit not refused");
  AST_SYNC_BYTE: assert property ( // [RULE_05]
    mem_req && mem_sync |-> !mem_word)
    else $error("synced access not byte sized");
  AST_SYNC_DIR: assert property ( // [RULE_07]
    accept && op == xfer_pkg::OP_SYNC |=> mem_we == $past(dir) ##[1:8] mem_req)
    else $error("synced direction wrong or late");
  AST_SYNC_TICK: assert property ( // [RULE_06]
    $rose(mem_req) && mem_sync |-> $past(e_tick))
    else $error("synced cycle not on e boundary");
  AST_PUSH_DEC: assert property ( // [RULE_08]
    accept && op == xfer_pkg::OP_PUSH |=>
    regs_r[7] == $past(regs_r[7]) - 16'h0002 && mem_req && mem_we)
    else $error("push did not predecrement");
  AST_POP_INC: assert property ( // [RULE_09]
    mem_req && mem_ack && inc_r && inc_reg_r == 3'h7 && dst_r[2:0] != 3'h7
    |=> regs_r[7] == $past(regs_r[7]) + 16'h0002)
    else $error("pop did not postincrement");
  AST_IMM_WORD: assert property ( // [RULE_11]
    accept && op == xfer_pkg::OP_LOAD && mode == xfer_pkg::MODE_IMM &&
    size_word |=> done && regs_r[$past(reg_field[2:0])] == $past(ext))
    else $error("word immediate not loaded");
  AST_REG_MOVE: assert property ( // [RULE_12]
    accept && op == xfer_pkg::OP_LOAD && mode == xfer_pkg::MODE_REG &&
    size_word |=> regs_r[$past(reg_field[2:0])] == $past(regs_r[ea_field[2:0]]))
    else $error("register move wrong");

  COV_PUSH: cover property (accept && op == xfer_pkg::OP_PUSH ##[1:20] done);
  COV_SYNC: cover property (mem_req && mem_sync && mem_ack);
  COV_ILLEGAL: cover property (illegal);
endmodule : xfer_exec

// ===== testbench/mem_model.sv
// memory and peripheral bus partner with a chosen wait
`timescale 1ns/1ps
module mem_model (
  // clock and wait length
  input wire logic clk,
  input wire logic [3:0] lat,
  // bus from the executor
  input wire logic mem_req,
  input wire logic mem_we,
  input wire logic mem_word,
  input wire logic [15:0] mem_addr,
  input wire logic [15:0] mem_wdata,
  output logic mem_ack = 1'b0,
  output logic [15:0] mem_rdata = 16'h0000
);
  logic [7:0] m [logic [15:0]];
  logic go;
  int n = 0;
  function automatic logic [7:0] rd(logic [15:0] a);
    return m.exists(a) ? m[a] : a[7:0] ^ 8'h5a;
  endfunction : rd
  assign go = mem_req && !mem_ack && n >= lat;
  // one cycle ack; idle data flips so a stale byte never matches
  always @(posedge clk) begin
    n <= mem_req && !mem_ack ? n + 1 : 0;
    mem_ack <= go;
    if (!go) mem_rdata <= ~mem_rdata;
    if (go) begin
      mem_rdata <= mem_word ? {rd(mem_addr), rd(mem_addr + 16'h0001)}
                            : {8'h00, rd(mem_addr)};
      if (mem_we) m[mem_addr] = mem_word ? mem_wdata[15:8] : mem_wdata[7:0];
      if (mem_we && mem_word) m[mem_addr + 16'h0001] = mem_wdata[7:0];
    end
  end
endmodule : mem_model

// ===== testbench/testbench.sv
// self-checking bench for the data transfer executor
`timescale 1ns/1ps
module testbench;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic start = 1'b0;
  xfer_pkg::op_type op = xfer_pkg::OP_LOAD;
  xfer_pkg::mode_type mode = xfer_pkg::MODE_REG;
  logic size_word = 1'b0;
  logic dir = 1'b0;
  logic [3:0] reg_field = 4'h0;
  logic [3:0] ea_field = 4'h0;
  logic [15:0] ext = 16'h0000;
  logic [2:0] view_sel = 3'h0;
  logic [3:0] lat = 4'h0;
  logic vreq = 1'b0;
  logic busy, done, illegal, mem_req, mem_we, mem_word, mem_sync;
  logic mem_ack, e_clk;
  logic [15:0] mem_addr, mem_wdata, mem_rdata, view_data;
  logic [34:0] seen;
  int errors = 0;
  int samples_checked = 0;
  int e_run = 0;
  logic e_last = 1'b0;
  logic e_armed = 1'b0;
  logic [15:0] r [8];
  logic [7:0] sm [logic [15:0]];
  logic [34:0] bq [$];
  logic [15:0] vq [$];
  logic dq [$];

  xfer_exec u_xfer_exec (.clk, .rstn, .start, .op, .mode, .size_word,
    .dir, .reg_field, .ea_field, .ext, .busy, .done, .illegal, .mem_req,
    .mem_we, .mem_word, .mem_sync, .mem_addr, .mem_wdata, .mem_ack,
    .mem_rdata, .e_clk, .view_sel, .view_data);
  mem_model u_mem_model (.clk, .lat, .mem_req, .mem_we, .mem_word,
    .mem_addr, .mem_wdata, .mem_ack, .mem_rdata);

  // 100 MHz system clock
  always #5 clk = ~clk;

  task automatic check(logic [34:0] got, logic [34:0] exp);
    samples_checked++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, got, exp);
    end
  endtask : check

  task automatic final_report();
    if (errors == 0 && samples_checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : final_report

  // outputs settle by the falling edge, so compare there
  always @(negedge clk) begin
    if (mem_req && mem_ack) begin
      seen = {mem_we, mem_word, mem_sync, mem_addr, mem_wdata};
      if (!mem_we) seen[15:0] = 16'h0000;
      if (!mem_word) seen[15:8] = 8'h00;
      check(seen, bq.pop_front());
    end
    if (done === 1'b1)
      check(35'({busy, illegal}), 35'({1'b0, dq.pop_front()}));
    if (vreq) check(35'(view_data), 35'(vq.pop_front()));
    // each e clock half lasts half the divider count; the first low
    // phase is skipped because it also spans the reset time
    if (e_clk !== e_last) begin
      if (e_armed)
        check(35'(e_run), 35'(xfer_pkg::E_DIV / 2));
      e_armed = 1'b1;
      e_run = 0;
    end
    e_last = e_clk;
    e_run++;
  end

  function automatic logic [7:0] mb(logic [15:0] a);
    return sm.exists(a) ? sm[a] : a[7:0] ^ 8'h5a;
  endfunction : mb

  // register value seen through a field: word or byte half
  function automatic logic [15:0] gv(logic [3:0] f, logic w);
    logic [15:0] q;
    q = r[f[2:0]];
    return w ? q : {8'h00, f[3] ? q[7:0] : q[15:8]};
  endfunction : gv

  task automatic sv(logic [3:0] f, logic w, logic [15:0] v);
    if (w) r[f[2:0]] = v;
    else if (f[3]) r[f[2:0]][7:0] = v[7:0];
    else r[f[2:0]][15:8] = v[7:0];
  endtask : sv

  // reference move, note its results, then issue it
  task automatic run(xfer_pkg::op_type o, xfer_pkg::mode_type m,
                     logic w, logic d, logic [3:0] rf, logic [3:0] ea,
                     logic [15:0] x);
    logic ls, pp, ww, wr, ill, upd;
    logic [15:0] a, v, sd, st, np;
    logic [2:0] j;
    ls = o inside {xfer_pkg::OP_LOAD, xfer_pkg::OP_STORE};
    pp = o inside {xfer_pkg::OP_PUSH, xfer_pkg::OP_POP};
    j = pp ? xfer_pkg::SP_INDEX : ea[2:0];
    ww = pp || (ls && w);
    st = ww ? 16'h0002 : 16'h0001;
    wr = o == xfer_pkg::OP_STORE || o == xfer_pkg::OP_PUSH || (!ls && !pp && d);
    ill = ls && ((w && m == xfer_pkg::MODE_ABS8) ||
      (o == xfer_pkg::OP_STORE && m == xfer_pkg::MODE_IMM) ||
      (!w && j == 3'h7 && m inside {xfer_pkg::MODE_PREDEC,
                                    xfer_pkg::MODE_POSTINC}));
    upd = !ill && (pp || (ls && m inside {xfer_pkg::MODE_PREDEC,
                                          xfer_pkg::MODE_POSTINC}));
    np = (o == xfer_pkg::OP_PUSH || (ls && m == xfer_pkg::MODE_PREDEC)) ?
         r[j] - st : r[j] + st;
    case (m)
      xfer_pkg::MODE_DISP: a = r[j] + x;
      xfer_pkg::MODE_ABS16: a = x;
      xfer_pkg::MODE_ABS8: a = {xfer_pkg::ABS8_PAGE, x[7:0]};
      xfer_pkg::MODE_PREDEC: a = np;
      default: a = r[j];
    endcase
    if (!ls) a = pp ? (o == xfer_pkg::OP_PUSH ? np : r[7]) : x;
    if (ww) a[0] = 1'b0;
    sd = gv(rf, ww);
    v = ww ? {mb(a), mb(a + 16'h0001)} : {8'h00, mb(a)};
    if (ls && m == xfer_pkg::MODE_IMM) v = x;
    dq.push_back(ill);
    if (!ill && !(ls && m inside {xfer_pkg::MODE_REG, xfer_pkg::MODE_IMM})) begin
      bq.push_back({wr, ww, !ls && !pp, a, wr ? sd : 16'h0000});
      if (wr) sm[a] = ww ? sd[15:8] : sd[7:0];
      if (wr && ww) sm[a + 16'h0001] = sd[7:0];
    end
    // register moves: a store writes the register named by ea
    if (ls && m == xfer_pkg::MODE_REG) v = wr ? sd : gv(ea, w);
    if (!ill && (!wr || (ls && m == xfer_pkg::MODE_REG)))
      sv(wr ? ea : rf, ww, v);
    // pointer step wins over a load into the same register
    if (upd) r[j] = np;
    @(posedge clk);
    start <= 1'b1;
    op <= o;
    mode <= m;
    size_word <= w;
    dir <= d;
    reg_field <= rf;
    ea_field <= ea;
    ext <= x;
    lat <= 4'($urandom_range(0, 4));
    @(posedge clk);
    start <= 1'b0;
    for (int k = 0; k < 40 && done !== 1'b1; k++) @(negedge clk);
  endtask : run

  task automatic dump_regs();
    for (int s = 0; s < 8; s++) begin
      @(posedge clk);
      view_sel <= 3'(s);
      vq.push_back(r[s]);
      @(posedge clk);
      vreq <= 1'b1;
      @(posedge clk);
      vreq <= 1'b0;
    end
  endtask : dump_regs

  // watchdog far beyond the few hundred cycles the tests need
  initial begin
    repeat (50000) @(posedge clk);
    errors++;
    final_report();
  end

  initial begin
    logic [3:0] ra, rb;
    logic [15:0] x;
    void'($urandom(32'hfa1c));
    for (int s = 0; s < 8; s++) r[s] = 16'h0000;
    repeat (12) @(posedge clk);
    rstn <= 1'b1;
    dump_regs();
    // word immediates into every register, byte immediates into the low halves of two
    for (int s = 0; s < 10; s++) begin
      run(xfer_pkg::OP_LOAD, xfer_pkg::MODE_IMM, s < 8, 1'b0, 4'(s + 2),
          4'h0, 16'($urandom));
    end
    // every mode, both sizes, store then load through the same fields
    for (int k = 0; k < 16; k++) begin
      ra = 4'($urandom);
      rb = {1'($urandom), 3'(ra[2:0] + 3'($urandom_range(1, 7)))};
      x = 16'($urandom);
      run(xfer_pkg::OP_STORE, xfer_pkg::mode_type'(k[3:1]), k[0], 1'b0,
          ra, rb, x);
      run(xfer_pkg::OP_LOAD, xfer_pkg::mode_type'(k[3:1]), k[0], 1'b0,
          ra, rb, x);
    end
    // byte stack steps are refused
    run(xfer_pkg::OP_LOAD, xfer_pkg::MODE_PREDEC, 1'b0, 1'b0, 4'h1, 4'h7,
        16'h0000);
    run(xfer_pkg::OP_STORE, xfer_pkg::MODE_POSTINC, 1'b0, 1'b0, 4'h9, 4'hf,
        16'h0000);
    // size left at byte and a mode given: stack ops ignore both
    run(xfer_pkg::OP_PUSH, xfer_pkg::MODE_REG, 1'b0, 1'b0, 4'h2, 4'h0,
        16'h0000);
    run(xfer_pkg::OP_PUSH, xfer_pkg::MODE_REG, 1'b0, 1'b0, 4'h3, 4'h0,
        16'h0000);
    run(xfer_pkg::OP_POP, xfer_pkg::MODE_PREDEC, 1'b0, 1'b0, 4'h5, 4'h0,
        16'h0000);
    run(xfer_pkg::OP_POP, xfer_pkg::MODE_REG, 1'b0, 1'b0, 4'h7, 4'h0,
        16'h0000);
    // e clock timed byte store then load at one address
    x = 16'($urandom);
    for (int d = 1; d >= 0; d--) begin
      run(xfer_pkg::OP_SYNC, xfer_pkg::MODE_REG, 1'b1, 1'(d),
          4'($urandom), 4'h0, x);
    end
    dump_regs();
    // a note still queued means its result never showed up
    check(35'(bq.size() + dq.size() + vq.size()), 35'h0);
    final_report();
  end
endmodule : testbench
